// file: lhp_consts.svh
`ifndef LHP_CONSTS_SVH
`define LHP_CONSTS_SVH
`define LHP_COLS 132
`define LHP_LAST_COL 8'h83
`define LHP_ICON_PAGE 4'h8
`define LHP_ICON_COM 7'h40
`define LHP_LAST_LINE 7'h3f
`define LHP_MEM_WORDS 1188
`define LHP_MEM_AW 11
`define LHP_START_RST 6'h00
`define LHP_COL_RST 8'h00
`define LHP_PAGE_RST 4'h0
`define LHP_I_DISP 8'hae
`define LHP_M_DISP 8'hfe
`define LHP_I_START 8'h40
`define LHP_M_START 8'hc0
`define LHP_I_PAGE 8'hb0
`define LHP_M_PAGE 8'hf0
`define LHP_I_COLH 8'h10
`define LHP_I_COLL 8'h00
`define LHP_M_COL 8'hf0
`define LHP_I_SEG 8'ha0
`define LHP_I_INV 8'ha6
`define LHP_I_ALLON 8'ha4
`define LHP_M_FLAG 8'hfe
`define LHP_I_RMW 8'he0
`define LHP_I_END 8'hee
`define LHP_I_RESET 8'he2
`define LHP_I_COM 8'hc0
`define LHP_M_COM 8'hf0
`define LHP_I_PWR 8'h28
`define LHP_M_PWR 8'hf8
`define LHP_I_EV 8'h81
`define LHP_I_BOOST 8'hf8
`endif

// file: lhp_pkg.sv
package lhp_pkg;
	typedef struct packed {
		logic cs_n;
		logic cs;
		logic a0;
		logic e_rd;
		logic rw_wr;
		logic par;
		logic style;
		logic tick;
		logic [7:0] d;
	} lhp_pins_t;
	typedef struct packed {
		logic booster;
		logic regulator;
		logic follower;
	} lhp_pwr_t;
	typedef struct packed {
		lhp_pins_t s1;
		lhp_pins_t s2;
		lhp_pins_t s3;
		logic act;
		logic rd;
		logic a0q;
		logic [7:0] dout;
		logic oe;
		logic [7:0] sh;
		logic [2:0] bits;
		logic [7:0] latch;
		logic [3:0] page;
		logic [7:0] col;
		logic [5:0] start;
		logic seg_rev;
		logic com_rev;
		logic disp_on;
		logic inverse;
		logic all_on;
		logic rmw;
		lhp_pwr_t pwr;
		logic pend;
		logic [6:0] com;
		logic [7:0] fcol;
		logic fetch;
		logic [131:0] rowbuf;
		logic [131:0] seg;
		logic [6:0] com_out;
	} lhp_state_t;
endpackage

// file: lhp_host_port.sv
// Operation
// R1: only act while low select is low and high select high; else float data.
// R2: parallel strap high gives parallel port, bus style picks 6800 or 8080; low gives serial.
// R3: select high means display data, low means status or instruction; direction picks read/write.
// R4: host strobes enable with direction (6800) or separate read/write strobes (8080).
// R5: serial data sampled on every rising serial clock while selected.
// R6: eighth serial clock forms a byte; select sampled then decides data or instruction.
// R7: serial shift register and bit counter cleared whenever deselected.
// R8: serial port is write only.
// R9: column pointer advances after each display data access.
// R10: column stops at the last column, never carries into the page.
// R11: first data read after addressing returns the stale bus latch.
// R12: data write lands in the bus latch then in RAM automatically.
// R13: RAM is 132 columns by 65 rows: eight byte pages plus icon page.
// R14: bit zero is the top pixel; icon page keeps only bit zero.
// R15: host uses only columns 0 to 131 and pages 0 to 8.
// R16: page pointer is four bits, changed only by page set and the reset instruction, which clears it to page 0.
// R17: host writes and scan reads share RAM without corruption.
// R18: start line picks the row on the first common; a counter scrolls from it.
// R19: icon row always drives the last common, never scrolled.
// R20: segment and common reverse mirror the RAM to output mapping.
// R21: inverse, display off and all-on only alter the output latch.
// R22: three power bits enable booster, regulator and follower separately.
// R23: column set by two instructions: upper nibble and lower nibble.
// R24: read-modify-write mode: reads hold the column, writes advance it.
// R25: host strobes and selects pass two flip-flops before decoding.
// R26: data accesses with the pointer out of range leave RAM alone.
`include "lhp_consts.svh"
module lhp_host_port
	import lhp_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// straps
	input wire logic par_ser_strap,
	input wire logic bus_style_strap,
	// host bus
	input wire logic select_low_active,
	input wire logic select_high_active,
	input wire logic cmd_data_select,
	input wire logic enable_read,
	input wire logic dir_write,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe,
	// display oscillator line tick
	input wire logic line_tick,
	// display outputs
	output logic [131:0] seg_out,
	output logic [6:0] com_index,
	output logic first_common_out,
	output logic icon_common_out,
	// power enables
	output logic booster_enable,
	output logic regulator_enable,
	output logic follower_enable
);
	lhp_state_t q;
	lhp_state_t n;
	logic [7:0] mem [0:`LHP_MEM_WORDS-1];
	logic mem_we;
	logic [`LHP_MEM_AW-1:0] mem_wa;
	logic [7:0] mem_wd;
	lhp_pins_t p;
	lhp_pins_t pp;
	logic sel;
	logic act;
	logic rdir;
	logic wr_go;
	logic rd_go;
	logic wr_a0;
	logic [7:0] wr_byte;
	logic legal;
	logic icon;
	logic [`LHP_MEM_AW-1:0] haddr;
	logic [7:0] hq;
	logic [7:0] status;
	logic [6:0] vline;
	logic [5:0] row;
	logic [3:0] spage;
	logic [`LHP_MEM_AW-1:0] saddr;
	logic [7:0] sq;
	logic sbit;
	logic [7:0] segidx;
	logic [7:0] dmask;

	function automatic logic hit(input logic [7:0] b, input logic [7:0] v, input logic [7:0] m);
		hit = (b & m) == v;
	endfunction

	function automatic logic [`LHP_MEM_AW-1:0] addr_of(input logic [3:0] pg, input logic [7:0] c);
		logic [15:0] a;
		a = 16'(pg) * 16'(`LHP_COLS) + 16'(c);
		addr_of = a[`LHP_MEM_AW-1:0];
	endfunction

	always_comb begin
		n = q;
		p = q.s2;
		pp = q.s3;
		mem_we = 1'b0;
		mem_wa = '0;
		mem_wd = 8'h00;
		wr_go = 1'b0;
		rd_go = 1'b0;
		wr_a0 = 1'b0;
		wr_byte = 8'h00;
		// two-stage synchronisers on every pin
		n.s1.cs_n = select_low_active; // see R25
		n.s1.cs = select_high_active;
		n.s1.a0 = cmd_data_select;
		n.s1.e_rd = enable_read;
		n.s1.rw_wr = dir_write;
		n.s1.par = par_ser_strap;
		n.s1.style = bus_style_strap;
		n.s1.tick = line_tick;
		n.s1.d = data_in;
		n.s2 = q.s1; // see R25
		n.s3 = q.s2;
		sel = ~p.cs_n & p.cs; // see R1
		// 6800: enable high; 8080: either strobe low
		act = p.par & sel & (p.style ? p.e_rd : (~p.e_rd | ~p.rw_wr)); // see R2
		rdir = p.style ? p.rw_wr : ~p.e_rd; // see R4
		legal = (q.page <= `LHP_ICON_PAGE) && (q.col <= `LHP_LAST_COL); // see R26
		icon = q.page == `LHP_ICON_PAGE;
		dmask = icon ? 8'h01 : 8'hff; // see R14
		haddr = legal ? addr_of(q.page, q.col) : '0;
		hq = mem[haddr];
		status = {1'b0, q.seg_rev, q.disp_on, 1'b0, 4'h0};
		// parallel transfer start: drive read data
		if (act && !q.act) begin
			n.rd = rdir;
			n.a0q = p.a0;
			n.oe = rdir;
			n.dout = p.a0 ? q.latch : status; // see R3, R11
		end
		// parallel transfer end: commit
		if (!act && q.act) begin
			n.oe = 1'b0; // see R1
			if (q.rd) begin
				rd_go = q.a0q; // see R3
			end else begin
				wr_go = 1'b1;
				// data from the last sample with the strobe still active; hold time may be zero
				wr_byte = pp.d; // see R12
				wr_a0 = q.a0q; // see R3
			end
		end
		n.act = act;
		// serial receiver, write only
		if (!p.par) begin
			if (!sel) begin
				n.sh = 8'h00; // see R7
				n.bits = 3'h0; // see R7
			end else if (p.d[6] && !pp.d[6]) begin
				n.sh = {q.sh[6:0], p.d[7]}; // see R5
				n.bits = q.bits + 3'h1;
				if (q.bits == 3'h7) begin
					wr_go = 1'b1; // see R6
					wr_byte = {q.sh[6:0], p.d[7]};
					wr_a0 = p.a0; // see R6
				end
			end
		end
		// display data write
		if (wr_go && wr_a0) begin
			n.latch = wr_byte & dmask; // see R12
			if (legal) begin
				mem_we = 1'b1; // see R12, R26
				mem_wa = haddr;
				mem_wd = wr_byte & dmask; // see R14
				if (q.col < `LHP_LAST_COL) begin
					n.col = q.col + 8'h01; // see R9, R10, R24
				end
			end
		end
		// display data read: refill latch for the next read
		if (rd_go && legal) begin
			n.latch = hq & dmask; // see R11, R14
			if (!q.rmw && q.col < `LHP_LAST_COL) begin
				n.col = q.col + 8'h01; // see R9, R10, R24
			end
		end
		// instruction decode
		if (wr_go && !wr_a0) begin
			if (q.pend) begin
				n.pend = 1'b0;
			end else if (hit(wr_byte, `LHP_I_EV, 8'hff) || hit(wr_byte, `LHP_I_BOOST, 8'hff)) begin
				n.pend = 1'b1;
			end else if (hit(wr_byte, `LHP_I_DISP, `LHP_M_DISP)) begin
				n.disp_on = wr_byte[0];
			end else if (hit(wr_byte, `LHP_I_START, `LHP_M_START)) begin
				n.start = wr_byte[5:0]; // see R18
			end else if (hit(wr_byte, `LHP_I_PAGE, `LHP_M_PAGE)) begin
				n.page = wr_byte[3:0]; // see R16
			end else if (hit(wr_byte, `LHP_I_COLH, `LHP_M_COL)) begin
				n.col = {wr_byte[3:0], q.col[3:0]}; // see R23
			end else if (hit(wr_byte, `LHP_I_COLL, `LHP_M_COL)) begin
				n.col = {q.col[7:4], wr_byte[3:0]}; // see R23
			end else if (hit(wr_byte, `LHP_I_SEG, `LHP_M_FLAG)) begin
				n.seg_rev = wr_byte[0]; // see R20
			end else if (hit(wr_byte, `LHP_I_INV, `LHP_M_FLAG)) begin
				n.inverse = wr_byte[0];
			end else if (hit(wr_byte, `LHP_I_ALLON, `LHP_M_FLAG)) begin
				n.all_on = wr_byte[0];
			end else if (hit(wr_byte, `LHP_I_RMW, 8'hff)) begin
				n.rmw = 1'b1; // see R24
			end else if (hit(wr_byte, `LHP_I_END, 8'hff)) begin
				n.rmw = 1'b0;
			end else if (hit(wr_byte, `LHP_I_RESET, 8'hff)) begin
				n.rmw = 1'b0;
				n.start = `LHP_START_RST;
				n.col = `LHP_COL_RST;
				n.page = `LHP_PAGE_RST;
				n.com_rev = 1'b0;
			end else if (hit(wr_byte, `LHP_I_COM, `LHP_M_COM)) begin
				n.com_rev = wr_byte[3]; // see R20
			end else if (hit(wr_byte, `LHP_I_PWR, `LHP_M_PWR)) begin
				n.pwr = '{booster: wr_byte[2], regulator: wr_byte[1], follower: wr_byte[0]}; // see R22
			end
		end
		// display scan: one column per free cycle into the row buffer
		vline = q.com_rev ? (`LHP_LAST_LINE - q.com) : q.com; // see R20
		row = q.start + vline[5:0]; // see R18
		spage = (q.com == `LHP_ICON_COM) ? `LHP_ICON_PAGE : {1'b0, row[5:3]}; // see R19
		saddr = addr_of(spage, q.fcol);
		sq = mem[saddr];
		sbit = (q.com == `LHP_ICON_COM) ? sq[0] : sq[row[2:0]]; // see R13, R14, R19
		segidx = q.seg_rev ? (`LHP_LAST_COL - q.fcol) : q.fcol; // see R20
		if (p.tick && !pp.tick && !q.fetch) begin
			n.fetch = 1'b1;
			n.fcol = 8'h00;
		end
		// host strobes take the cycle; scan waits
		if (q.fetch && !act && !q.act) begin
			n.rowbuf[segidx] = sbit; // see R17
			n.fcol = q.fcol + 8'h01;
			if (q.fcol == `LHP_LAST_COL) begin
				n.fetch = 1'b0;
				if (!q.disp_on) begin
					n.seg = '0; // see R21
				end else if (q.all_on) begin
					n.seg = '1; // see R21
				end else begin
					n.seg = q.inverse ? ~n.rowbuf : n.rowbuf; // see R21
				end
				n.com_out = q.com;
				n.com = (q.com == `LHP_ICON_COM) ? 7'h00 : q.com + 7'h01; // see R18, R19
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	// no reset: RAM content undefined after power-up
	always_ff @(posedge clk) begin
		if (mem_we) begin
			mem[mem_wa] <= mem_wd; // see R12
		end
	end

	assign data_out = q.dout;
	assign data_oe = q.oe; // see R1, R8
	assign seg_out = q.seg;
	assign com_index = q.com_out;
	assign first_common_out = q.com_out == 7'h00;
	assign icon_common_out = q.com_out == `LHP_ICON_COM; // see R19
	assign booster_enable = q.pwr.booster; // see R22
	assign regulator_enable = q.pwr.regulator;
	assign follower_enable = q.pwr.follower;
endmodule

// file: lhp_host_port_properties.sv
module lhp_host_port_properties (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// host side
	input wire logic par_ser_strap,
	input wire logic bus_style_strap,
	input wire logic select_low_active,
	input wire logic select_high_active,
	input wire logic enable_read,
	input wire logic dir_write,
	input wire logic data_oe,
	// display and power
	input wire logic [6:0] com_index,
	input wire logic first_common_out,
	input wire logic icon_common_out,
	input wire logic booster_enable,
	input wire logic regulator_enable,
	input wire logic follower_enable
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	sequence s_rd8080;
		(par_ser_strap && !bus_style_strap && !select_low_active && select_high_active && !enable_read && dir_write)[*5];
	endsequence
	sequence s_idle_cs;
		select_low_active[*5];
	endsequence
	a_desel_float: assert property (s_idle_cs |-> !data_oe) else $error("bus driven while deselected");
	a_desel_high: assert property (!select_high_active[*5] |-> !data_oe) else $error("bus driven while deselected");
	a_serial_quiet: assert property (!par_ser_strap[*5] |-> !data_oe) else $error("bus driven in serial mode");
	a_read_drives: assert property (s_rd8080 |-> data_oe) else $error("read strobe not answered");
	a_first_com: assert property (first_common_out |-> com_index == 7'h00) else $error("first common flag wrong");
	a_icon_com: assert property (icon_common_out == (com_index == 7'h40)) else $error("icon common flag wrong");
	a_com_range: assert property (com_index <= 7'h40) else $error("common index too large");
	a_com_step: assert property ($changed(com_index) |->
		com_index == (($past(com_index) == 7'h40) ? 7'h00 : $past(com_index) + 7'h01)) else $error("row skipped");
	a_power_hold: assert property (select_low_active[*6] |=>
		$stable({booster_enable, regulator_enable, follower_enable})) else $error("power bits moved");
endmodule

// file: lhp_host_model.sv
module lhp_host_model (
	// clock and mode
	input wire logic clk,
	input wire logic bus_style_strap,
	// bus to device
	output logic select_low_active,
	output logic cmd_data_select,
	output logic enable_read,
	output logic dir_write,
	output logic [7:0] data_in,
	// bus from device
	input wire logic [7:0] data_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		select_low_active = 1'b1;
		cmd_data_select = 1'b1;
		enable_read = 1'b1;
		dir_write = 1'b1;
		data_in = 8'hff;
	end
	task automatic xfer(input logic rd, input logic a0, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		select_low_active <= 1'b0;
		cmd_data_select <= a0;
		data_in <= rd ? ~data_in : d;
		enable_read <= bus_style_strap | !rd;
		dir_write <= rd;
		repeat (6) @(posedge clk);
		q = data_out;
		select_low_active <= 1'b1;
		enable_read <= !bus_style_strap;
		dir_write <= 1'b1;
		data_in <= ~data_in;
		repeat (4) @(posedge clk);
	endtask
	task automatic ser(input logic a0, input logic [7:0] d);
		integer i;
		@(posedge clk);
		select_low_active <= 1'b0;
		for (i = 7; i >= 0; i--) begin
			data_in[7:6] <= {d[i], 1'b0};
			cmd_data_select <= a0;
			repeat (4) @(posedge clk);
			data_in[6] <= 1'b1;
			repeat (4) @(posedge clk);
		end
		select_low_active <= 1'b1;
		data_in[7:6] <= {~d[0], 1'b0};
		repeat (4) @(posedge clk);
	endtask
endmodule

// file: lcd_host_port_ram_addressing_tb.sv
module lcd_host_port_ram_addressing_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rstn, par_ser_strap, bus_style_strap, select_high_active;
	logic line_tick = 1'b0;
	logic select_low_active, cmd_data_select, enable_read, dir_write, data_oe;
	logic first_common_out, icon_common_out, booster_enable, regulator_enable, follower_enable;
	logic [7:0] data_in, data_out;
	logic [7:0] tk = 8'h00;
	logic [131:0] seg_out;
	logic [6:0] com_index;
	logic [2:0] pw [4] = '{3'h7, 3'h3, 3'h1, 3'h0};
	int n_errors = 0;
	int n_checks = 0;
	int i;
	always #20 clk = ~clk;
	always @(posedge clk) begin
		tk <= tk + 8'h01;
		line_tick <= tk[7];
	end
	lhp_host_port u_dut (.clk, .rstn, .par_ser_strap, .bus_style_strap, .select_low_active, .select_high_active,
		.cmd_data_select, .enable_read, .dir_write, .data_in, .data_out, .data_oe, .line_tick, .seg_out,
		.com_index, .first_common_out, .icon_common_out, .booster_enable, .regulator_enable, .follower_enable);
	lhp_host_model u_host (.clk, .bus_style_strap, .select_low_active, .cmd_data_select, .enable_read,
		.dir_write, .data_in, .data_out);
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
			n_errors++;
		end
	endtask
	task automatic wr(input logic a0, input logic [7:0] d);
		logic [7:0] x;
		u_host.xfer(1'b0, a0, d, x);
	endtask
	task automatic rd(input logic a0, input logic [7:0] exp);
		logic [7:0] x;
		u_host.xfer(1'b1, a0, 8'h00, x);
		chk(x, exp);
	endtask
	task automatic at(input logic [3:0] pg, input logic [7:0] col, input logic dummy);
		logic [7:0] x;
		wr(1'b0, {4'hb, pg});
		wr(1'b0, {4'h1, col[7:4]});
		wr(1'b0, {4'h0, col[3:0]});
		if (dummy) u_host.xfer(1'b1, 1'b1, 8'h00, x);
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		par_ser_strap = 1'b1;
		bus_style_strap = 1'b0;
		select_high_active = 1'b1;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		wr(1'b0, 8'haf);
		wr(1'b0, 8'ha1);
		rd(1'b0, 8'h60);
		wr(1'b0, 8'ha0);
		at(4'h0, 8'h00, 1'b0);
		wr(1'b1, 8'h5a);
		wr(1'b1, 8'ha5);
		at(4'h0, 8'h00, 1'b1);
		rd(1'b1, 8'h5a);
		rd(1'b1, 8'ha5);
		at(4'h0, 8'h83, 1'b0);
		wr(1'b1, 8'h11);
		wr(1'b1, 8'h22);
		at(4'h0, 8'h83, 1'b1);
		rd(1'b1, 8'h22);
		at(4'h8, 8'h00, 1'b0);
		wr(1'b1, 8'hff);
		at(4'h8, 8'h00, 1'b1);
		rd(1'b1, 8'h01);
		$display("test addressing done");
		wr(1'b0, 8'he0);
		at(4'h0, 8'h01, 1'b1);
		rd(1'b1, 8'ha5);
		wr(1'b1, 8'h3c);
		wr(1'b0, 8'hee);
		at(4'h0, 8'h01, 1'b1);
		rd(1'b1, 8'h3c);
		at(4'h0, 8'h00, 1'b0);
		select_high_active <= 1'b0;
		wr(1'b1, 8'h77);
		select_high_active <= 1'b1;
		at(4'h0, 8'h00, 1'b1);
		rd(1'b1, 8'h5a);
		for (i = 0; i < 4; i++) begin
			wr(1'b0, {5'h05, pw[i]});
			chk({5'h00, booster_enable, regulator_enable, follower_enable}, {5'h00, pw[i]});
		end
		$display("test modes done");
		bus_style_strap <= 1'b1;
		repeat (4) @(posedge clk);
		at(4'h1, 8'h07, 1'b0);
		wr(1'b1, 8'hc3);
		at(4'h1, 8'h07, 1'b1);
		rd(1'b1, 8'hc3);
		par_ser_strap <= 1'b0;
		repeat (4) @(posedge clk);
		u_host.ser(1'b0, 8'hb2);
		u_host.ser(1'b0, 8'h10);
		u_host.ser(1'b0, 8'h05);
		u_host.ser(1'b1, 8'h96);
		u_host.ser(1'b1, 8'h69);
		par_ser_strap <= 1'b1;
		repeat (4) @(posedge clk);
		at(4'h2, 8'h05, 1'b1);
		rd(1'b1, 8'h96);
		rd(1'b1, 8'h69);
		$display("test serial done");
		wr(1'b0, 8'ha5);
		repeat (600) @(posedge clk);
		chk(seg_out[7:0], 8'hff);
		chk(seg_out[131:124], 8'hff);
		wr(1'b0, 8'ha4);
		wr(1'b0, 8'hae);
		repeat (600) @(posedge clk);
		chk(seg_out[7:0], 8'h00);
		at(4'h2, 8'h05, 1'b1);
		rd(1'b1, 8'h96);
		$display("test output latch done");
		end_of_test;
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		end_of_test;
	end
endmodule
bind lhp_host_port lhp_host_port_properties u_props (.clk, .rstn, .par_ser_strap, .bus_style_strap,
	.select_low_active, .select_high_active, .enable_read, .dir_write, .data_oe, .com_index,
	.first_common_out, .icon_common_out, .booster_enable, .regulator_enable, .follower_enable);
